// file: common/api_frame_pkg.sv
package api_frame_pkg;
   // ==========================================
   // framing bytes
   localparam logic [7:0] START_DELIM = 8'h7E;
   localparam logic [7:0] ESC_BYTE = 8'h7D;
   localparam logic [7:0] ESC_XOR = 8'h20;
   localparam logic [7:0] XON_BYTE = 8'h11;
   localparam logic [7:0] XOFF_BYTE = 8'h13;
   localparam logic [7:0] SUM_GOOD = 8'hFF;
   localparam logic [7:0] LEN_HI_BYTE = 8'h00;
   localparam logic [1:0] MODE_ESCAPED = 2'h2;
   // ==========================================
   // frame types
   localparam logic [7:0] T_LOCAL_CMD = 8'h08;
   localparam logic [7:0] T_QUEUE_CMD = 8'h09;
   localparam logic [7:0] T_TX_REQ = 8'h10;
   localparam logic [7:0] T_TX_EXPL = 8'h11;
   localparam logic [7:0] T_REMOTE_CMD = 8'h17;
   localparam logic [7:0] T_LOCAL_RSP = 8'h88;
   localparam logic [7:0] T_TX_STATUS = 8'h8B;
   localparam logic [7:0] T_RX_PLAIN = 8'h90;
   localparam logic [7:0] T_RX_EXPL = 8'h91;
   localparam logic [7:0] T_REMOTE_RSP = 8'h97;
   // ==========================================
   // body offsets and sizes
   localparam logic [15:0] OFS_TYPE = 16'h0000;
   localparam logic [15:0] OFS_ID = 16'h0001;
   localparam logic [15:0] OFS_CMD0 = 16'h0002;
   localparam logic [15:0] OFS_CMD1 = 16'h0003;
   localparam logic [15:0] CMD_HDR_LEN = 16'h0004;
   localparam logic [15:0] TX_HDR_LEN = 16'h0002;
   localparam logic [3:0] HDR_POS = 4'h3;
   localparam int BODY_MAX = 9;
   localparam int NUM_PARAMS = 8;
   localparam logic [3:0] LEN_CMD_RSP = 4'h5;
   localparam logic [3:0] LEN_QUERY_RSP = 4'h9;
   localparam logic [3:0] LEN_STATUS_RSP = 4'h3;
   localparam logic [3:0] LEN_RX_PLAIN = 4'h2;
   localparam logic [3:0] LEN_RX_EXPL = 4'h3;
   // ==========================================
   // status values and codes
   localparam logic [7:0] ST_OK = 8'h00;
   localparam logic [7:0] ST_REMOTE_NO_ACK = 8'h04;
   localparam logic [7:0] RX_EXPL_ENDPOINT = 8'hE8;
   localparam logic [15:0] APPLY_CODE = 16'h4143;
   localparam logic [7:0] ID_NONE = 8'h00;

   function automatic logic needs_esc(input logic [7:0] b);
      return (b == START_DELIM) || (b == ESC_BYTE) || (b == XON_BYTE) || (b == XOFF_BYTE);
   endfunction

   function automatic logic [2:0] param_index(input logic [7:0] c1);
      return c1[2:0];
   endfunction
endpackage

// file: common/api_link_if.sv
`timescale 1ns/10ps
interface api_link_if (
   input wire logic clk
);
   logic [7:0] h2d_data;
   logic h2d_valid;
   logic h2d_ready;
   logic [7:0] d2h_data;
   logic d2h_valid;
   logic d2h_ready;

   modport device_end (
      input clk, h2d_data, h2d_valid, d2h_ready,
      output h2d_ready, d2h_data, d2h_valid
   );
   modport host_end (
      input clk, h2d_ready, d2h_data, d2h_valid,
      output h2d_data, h2d_valid, d2h_ready
   );
endinterface

// file: design/api_frame_device.sv
`timescale 1ns/10ps
module api_frame_device (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // link
   api_link_if.device_end link,
   // configuration
   input wire logic [1:0] api_framing_select,
   input wire logic rx_explicit,
   input wire logic [7:0] delivery_cause,
   // radio receive data
   input wire logic rf_valid,
   input wire logic [7:0] rf_byte,
   output logic rf_ack,
   // parameter update
   output logic param_wr,
   output logic [15:0] param_code,
   output logic [31:0] param_value
);
   import api_frame_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_LEN_HI = 3'b001,
      S_LEN_LO = 3'b010,
      S_BODY = 3'b011,
      S_SUM = 3'b100,
      S_EXEC = 3'b101,
      S_SEND = 3'b110
   } state_t;

   state_t state_q;
   logic h2d_ready_q, esc_rx_q, esc_tx_q, d2h_valid_q;
   logic [7:0] d2h_data_q;
   logic [15:0] len_q, cnt_q;
   logic [7:0] sum_q, type_q, id_q, cmd0_q, cmd1_q, tx_sum_q;
   logic [31:0] par_q;
   logic [31:0] store_q [NUM_PARAMS];
   logic [31:0] pend_q [NUM_PARAMS];
   logic [NUM_PARAMS-1:0] pend_v_q;
   logic [7:0] rsp_q [BODY_MAX];
   logic [3:0] rsp_len_q, tx_pos_q;

   // ==========================================
   // receive decode
   wire esc_mode = (api_framing_select == MODE_ESCAPED);
   wire rx_take = link.h2d_valid & h2d_ready_q;
   wire esc_prefix = esc_mode & ~esc_rx_q & (link.h2d_data == ESC_BYTE);
   wire [7:0] rx_byte = esc_rx_q ? (link.h2d_data ^ ESC_XOR) : link.h2d_data;
   wire is_start = rx_take & ~esc_rx_q & (link.h2d_data == START_DELIM)
                   & (esc_mode | (state_q == S_IDLE));
   wire byte_v = rx_take & ~esc_prefix & ~is_start;
   wire [7:0] sum_next = sum_q + rx_byte;

   // ==========================================
   // request decode
   wire is_local = (type_q == T_LOCAL_CMD) | (type_q == T_QUEUE_CMD);
   wire is_tx = (type_q == T_TX_REQ) | (type_q == T_TX_EXPL);
   wire is_query = (len_q == CMD_HDR_LEN);
   wire [2:0] pidx = param_index(cmd1_q);
   wire is_apply = ({cmd0_q, cmd1_q} == APPLY_CODE);
   wire apply_all = (type_q == T_LOCAL_CMD) | is_apply;
   wire [31:0] qval = store_q[pidx];

   // ==========================================
   // transmit byte select
   wire [3:0] body_end = HDR_POS + rsp_len_q;
   wire [3:0] body_idx = tx_pos_q - HDR_POS;
   wire tx_load = ~d2h_valid_q | link.d2h_ready;
   wire tx_done = (tx_pos_q > body_end);
   wire in_body = (tx_pos_q >= HDR_POS) & (tx_pos_q < body_end);
   wire [7:0] tx_raw = (tx_pos_q == 4'h0) ? START_DELIM :
                       (tx_pos_q == 4'h1) ? LEN_HI_BYTE :
                       (tx_pos_q == 4'h2) ? {4'h0, rsp_len_q} :
                       in_body ? rsp_q[body_idx] : (SUM_GOOD - tx_sum_q);
   wire tx_esc = esc_mode & (tx_pos_q != 4'h0) & needs_esc(tx_raw);

   assign link.h2d_ready = h2d_ready_q;
   assign link.d2h_valid = d2h_valid_q;
   assign link.d2h_data = d2h_data_q;

   // ==========================================
   // frame receive
   always_ff @(posedge clk) begin
      rf_ack <= 1'b0;
      param_wr <= 1'b0;
      if (reset) begin
         state_q <= S_IDLE;
         h2d_ready_q <= 1'b1;
         esc_rx_q <= 1'b0;
         len_q <= 16'h0000;
         cnt_q <= 16'h0000;
         sum_q <= 8'h00;
         rsp_len_q <= 4'h0;
         pend_v_q <= '0;
         param_code <= 16'h0000;
         param_value <= 32'h0000_0000;
      end else begin
         if (rx_take) begin
            esc_rx_q <= esc_prefix;
         end
         if (is_start) begin
            state_q <= S_LEN_HI;
         end else begin
            case (state_q)
               S_IDLE: begin
                  if (rf_valid) begin
                     rf_ack <= 1'b1;
                     h2d_ready_q <= 1'b0;
                     state_q <= S_SEND;
                     if (rx_explicit) begin
                        rsp_q[0] <= T_RX_EXPL;
                        rsp_q[1] <= RX_EXPL_ENDPOINT;
                        rsp_q[2] <= rf_byte;
                        rsp_len_q <= LEN_RX_EXPL;
                     end else begin
                        rsp_q[0] <= T_RX_PLAIN;
                        rsp_q[1] <= rf_byte;
                        rsp_len_q <= LEN_RX_PLAIN;
                     end
                  end
               end
               S_LEN_HI: if (byte_v) begin
                  len_q[15:8] <= rx_byte;
                  state_q <= S_LEN_LO;
               end
               S_LEN_LO: if (byte_v) begin
                  len_q[7:0] <= rx_byte;
                  cnt_q <= 16'h0000;
                  sum_q <= 8'h00;
                  par_q <= '0;
                  state_q <= ({len_q[15:8], rx_byte} == 16'h0000) ? S_IDLE : S_BODY;
               end
               S_BODY: if (byte_v) begin
                  sum_q <= sum_next;
                  cnt_q <= cnt_q + 16'h0001;
                  if (cnt_q == OFS_TYPE) type_q <= rx_byte;
                  if (cnt_q == OFS_ID) id_q <= rx_byte;
                  if (cnt_q == OFS_CMD0) cmd0_q <= rx_byte;
                  if (cnt_q == OFS_CMD1) cmd1_q <= rx_byte;
                  if (cnt_q >= CMD_HDR_LEN) par_q <= {par_q[23:0], rx_byte};
                  if (cnt_q == len_q - 16'h0001) state_q <= S_SUM;
               end
               S_SUM: if (byte_v) begin
                  if (sum_next == SUM_GOOD) begin
                     state_q <= S_EXEC;
                     h2d_ready_q <= 1'b0;
                  end else begin
                     state_q <= S_IDLE;
                  end
               end
               S_EXEC: begin
                  state_q <= S_IDLE;
                  h2d_ready_q <= 1'b1;
                  rsp_q[1] <= id_q;
                  if (is_local & (len_q >= CMD_HDR_LEN)) begin
                     if (apply_all) begin
                        for (int i = 0; i < NUM_PARAMS; i++) begin
                           if (pend_v_q[i]) store_q[i] <= pend_q[i];
                        end
                        pend_v_q <= '0;
                     end
                     if (!is_query && !is_apply) begin
                        if (type_q == T_LOCAL_CMD) begin
                           store_q[pidx] <= par_q;
                           param_wr <= 1'b1;
                           param_code <= {cmd0_q, cmd1_q};
                           param_value <= par_q;
                        end else begin
                           pend_q[pidx] <= par_q;
                           pend_v_q[pidx] <= 1'b1;
                        end
                     end
                     rsp_q[0] <= T_LOCAL_RSP;
                     rsp_q[2] <= cmd0_q;
                     rsp_q[3] <= cmd1_q;
                     rsp_q[4] <= ST_OK;
                     rsp_q[5] <= qval[31:24];
                     rsp_q[6] <= qval[23:16];
                     rsp_q[7] <= qval[15:8];
                     rsp_q[8] <= qval[7:0];
                     rsp_len_q <= is_query ? LEN_QUERY_RSP : LEN_CMD_RSP;
                     if (id_q != ID_NONE) begin
                        state_q <= S_SEND;
                        h2d_ready_q <= 1'b0;
                     end
                  end else if (is_tx & (len_q >= TX_HDR_LEN)) begin
                     rsp_q[0] <= T_TX_STATUS;
                     rsp_q[2] <= delivery_cause;
                     rsp_len_q <= LEN_STATUS_RSP;
                     if (id_q != ID_NONE) begin
                        state_q <= S_SEND;
                        h2d_ready_q <= 1'b0;
                     end
                  end else if (type_q == T_REMOTE_CMD) begin
                     rsp_q[0] <= T_REMOTE_RSP;
                     rsp_q[2] <= ST_REMOTE_NO_ACK;
                     rsp_len_q <= LEN_STATUS_RSP;
                     state_q <= S_SEND;
                     h2d_ready_q <= 1'b0;
                  end
               end
               S_SEND: if (tx_load & tx_done) begin
                  state_q <= S_IDLE;
                  h2d_ready_q <= 1'b1;
               end
               default: state_q <= S_IDLE;
            endcase
         end
      end
   end

   // ==========================================
   // frame transmit
   always_ff @(posedge clk) begin
      if (reset || state_q != S_SEND) begin
         tx_pos_q <= 4'h0;
         tx_sum_q <= 8'h00;
         esc_tx_q <= 1'b0;
         if (reset || tx_load) d2h_valid_q <= 1'b0;
         if (reset) d2h_data_q <= 8'h00;
      end else if (tx_load) begin
         d2h_valid_q <= ~tx_done;
         if (!tx_done) begin
            if (tx_esc & ~esc_tx_q) begin
               d2h_data_q <= ESC_BYTE;
               esc_tx_q <= 1'b1;
            end else begin
               d2h_data_q <= esc_tx_q ? (tx_raw ^ ESC_XOR) : tx_raw;
               esc_tx_q <= 1'b0;
               tx_pos_q <= tx_pos_q + 4'h1;
               if (in_body) tx_sum_q <= tx_sum_q + tx_raw;
            end
         end
      end
   end
endmodule

// file: design/api_frame_host.sv
`timescale 1ns/10ps
module api_frame_host (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // link
   api_link_if.host_end link,
   // configuration
   input wire logic [1:0] api_framing_select,
   // command request
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_type,
   input wire logic [7:0] cmd_id,
   input wire logic [15:0] cmd_code,
   input wire logic [2:0] cmd_plen,
   input wire logic [31:0] cmd_param,
   output logic cmd_ready,
   // received frames
   output logic rsp_valid,
   output logic [7:0] rsp_type,
   output logic [7:0] rsp_id,
   output logic [15:0] rsp_len,
   output logic [63:0] rsp_data
);
   import api_frame_pkg::*;

   typedef enum logic [2:0] {
      R_IDLE = 3'b000,
      R_LEN_HI = 3'b001,
      R_LEN_LO = 3'b010,
      R_BODY = 3'b011,
      R_SUM = 3'b100
   } rstate_t;

   rstate_t rstate_q;
   logic esc_rx_q, esc_tx_q, h2d_valid_q, sending_q;
   logic [7:0] h2d_data_q, sum_q, tx_sum_q, type_q, id_q;
   logic [15:0] len_q, cnt_q;
   logic [63:0] data_q;
   logic [7:0] req_q [8];
   logic [3:0] req_len_q, tx_pos_q;

   // ==========================================
   // receive decode
   wire esc_mode = (api_framing_select == MODE_ESCAPED);
   wire rx_take = link.d2h_valid;
   wire esc_prefix = esc_mode & ~esc_rx_q & (link.d2h_data == ESC_BYTE);
   wire [7:0] rx_byte = esc_rx_q ? (link.d2h_data ^ ESC_XOR) : link.d2h_data;
   wire is_start = rx_take & ~esc_rx_q & (link.d2h_data == START_DELIM)
                   & (esc_mode | (rstate_q == R_IDLE));
   wire byte_v = rx_take & ~esc_prefix & ~is_start;
   wire [7:0] sum_next = sum_q + rx_byte;
   wire known = (type_q == T_LOCAL_RSP) | (type_q == T_TX_STATUS) | (type_q == T_RX_PLAIN)
                | (type_q == T_RX_EXPL) | (type_q == T_REMOTE_RSP);

   // ==========================================
   // transmit byte select
   wire [3:0] body_end = HDR_POS + req_len_q;
   wire [3:0] body_idx = tx_pos_q - HDR_POS;
   wire tx_load = ~h2d_valid_q | link.h2d_ready;
   wire tx_done = (tx_pos_q > body_end);
   wire in_body = (tx_pos_q >= HDR_POS) & (tx_pos_q < body_end);
   wire [7:0] tx_raw = (tx_pos_q == 4'h0) ? START_DELIM :
                       (tx_pos_q == 4'h1) ? LEN_HI_BYTE :
                       (tx_pos_q == 4'h2) ? {4'h0, req_len_q} :
                       in_body ? req_q[body_idx[2:0]] : (SUM_GOOD - tx_sum_q);
   wire tx_esc = esc_mode & (tx_pos_q != 4'h0) & needs_esc(tx_raw);
   wire cmd_take = cmd_valid & cmd_ready;

   assign link.d2h_ready = 1'b1;
   assign link.h2d_valid = h2d_valid_q;
   assign link.h2d_data = h2d_data_q;

   // ==========================================
   // frame receive
   always_ff @(posedge clk) begin
      rsp_valid <= 1'b0;
      if (reset) begin
         rstate_q <= R_IDLE;
         esc_rx_q <= 1'b0;
         len_q <= 16'h0000;
         cnt_q <= 16'h0000;
         sum_q <= 8'h00;
         rsp_type <= 8'h00;
         rsp_id <= 8'h00;
         rsp_len <= 16'h0000;
         rsp_data <= 64'h0000_0000_0000_0000;
      end else begin
         if (rx_take) esc_rx_q <= esc_prefix;
         if (is_start) begin
            rstate_q <= R_LEN_HI;
         end else begin
            case (rstate_q)
               R_IDLE: rstate_q <= R_IDLE;
               R_LEN_HI: if (byte_v) begin
                  len_q[15:8] <= rx_byte;
                  rstate_q <= R_LEN_LO;
               end
               R_LEN_LO: if (byte_v) begin
                  len_q[7:0] <= rx_byte;
                  cnt_q <= 16'h0000;
                  sum_q <= 8'h00;
                  data_q <= 64'h0000_0000_0000_0000;
                  rstate_q <= ({len_q[15:8], rx_byte} == 16'h0000) ? R_IDLE : R_BODY;
               end
               R_BODY: if (byte_v) begin
                  sum_q <= sum_next;
                  cnt_q <= cnt_q + 16'h0001;
                  if (cnt_q == OFS_TYPE) type_q <= rx_byte;
                  if (cnt_q == OFS_ID) id_q <= rx_byte;
                  if (cnt_q >= OFS_CMD0) data_q <= {data_q[55:0], rx_byte};
                  if (cnt_q == len_q - 16'h0001) rstate_q <= R_SUM;
               end
               R_SUM: if (byte_v) begin
                  rstate_q <= R_IDLE;
                  if ((sum_next == SUM_GOOD) && known) begin
                     rsp_valid <= 1'b1;
                     rsp_type <= type_q;
                     rsp_id <= id_q;
                     rsp_len <= len_q;
                     rsp_data <= data_q;
                  end
               end
               default: rstate_q <= R_IDLE;
            endcase
         end
      end
   end

   // ==========================================
   // command load and frame transmit
   always_ff @(posedge clk) begin
      if (reset) begin
         sending_q <= 1'b0;
         cmd_ready <= 1'b1;
         req_len_q <= 4'h0;
      end else if (cmd_take) begin
         sending_q <= 1'b1;
         cmd_ready <= 1'b0;
         req_q[0] <= cmd_type;
         req_q[1] <= cmd_id;
         req_q[2] <= cmd_code[15:8];
         req_q[3] <= cmd_code[7:0];
         for (int k = 0; k < 4; k++) begin
            req_q[4+k] <= cmd_param[8*(int'(cmd_plen)-1-k) +: 8];
         end
         req_len_q <= HDR_POS + 4'h1 + {1'b0, cmd_plen};
      end else if (sending_q & tx_load & tx_done) begin
         sending_q <= 1'b0;
         cmd_ready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !sending_q) begin
         tx_pos_q <= 4'h0;
         tx_sum_q <= 8'h00;
         esc_tx_q <= 1'b0;
         if (reset || tx_load) h2d_valid_q <= 1'b0;
         if (reset) h2d_data_q <= 8'h00;
      end else if (tx_load) begin
         h2d_valid_q <= ~tx_done;
         if (!tx_done) begin
            if (tx_esc & ~esc_tx_q) begin
               h2d_data_q <= ESC_BYTE;
               esc_tx_q <= 1'b1;
            end else begin
               h2d_data_q <= esc_tx_q ? (tx_raw ^ ESC_XOR) : tx_raw;
               esc_tx_q <= 1'b0;
               tx_pos_q <= tx_pos_q + 4'h1;
               if (in_body) tx_sum_q <= tx_sum_q + tx_raw;
            end
         end
      end
   end
endmodule

// file: tb/api_frame_monitor.sv
`timescale 1ns/10ps
module api_frame_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // link
   input wire logic [7:0] h2d_data,
   input wire logic h2d_valid,
   input wire logic h2d_ready,
   input wire logic [7:0] d2h_data,
   input wire logic d2h_valid,
   input wire logic d2h_ready
);
   import api_frame_pkg::*;
   // ==========
   // request tracker, undoes escapes
   logic [1:0] ph_q;
   logic [1:0] pos_q;
   logic esc_q;
   logic [15:0] left_q;
   logic [7:0] sum_q;
   logic [7:0] type_q;
   logic [7:0] id_q;
   wire take = h2d_valid && h2d_ready;
   wire [7:0] b = esc_q ? h2d_data ^ ESC_XOR : h2d_data;
   wire esc_in = take && h2d_data == ESC_BYTE && !esc_q;
   wire dat = take && h2d_data != START_DELIM && !esc_in;
   wire last = dat && ph_q == 2'd3 && left_q == 16'h0000;
   wire ok = last && 8'(sum_q + b) == SUM_GOOD;
   wire due = (type_q inside {T_LOCAL_CMD, T_QUEUE_CMD, T_TX_REQ, T_TX_EXPL} && id_q != ID_NONE)
      || type_q == T_REMOTE_CMD;
   always_ff @(posedge clk) begin
      if (reset || (take && h2d_data == START_DELIM)) begin
         ph_q <= reset ? 2'd0 : 2'd1;
         esc_q <= 1'b0;
      end else if (esc_in) begin
         esc_q <= 1'b1;
      end else if (dat) begin
         esc_q <= 1'b0;
         ph_q <= last ? 2'd0 : (ph_q == 2'd0 || ph_q == 2'd3) ? ph_q : ph_q + 2'd1;
         left_q <= ph_q == 2'd1 ? {b, 8'h00} : ph_q == 2'd2 ? {left_q[15:8], b} : left_q - 16'h0001;
         sum_q <= ph_q == 2'd3 ? sum_q + b : 8'h00;
         pos_q <= ph_q == 2'd3 ? pos_q + 2'(pos_q != 2'd3) : 2'd0;
         if (ph_q == 2'd3 && pos_q == 2'd0) type_q <= b;
         if (ph_q == 2'd3 && pos_q == 2'd1) id_q <= b;
      end
   end
   // ==========
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_reset_idle: assert property ($fell(reset) |-> h2d_ready && !d2h_valid)
      else $error("link not idle after reset");
   a_h2d_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
      else $error("host byte changed before taken");
   a_d2h_delim: assert property ($rose(d2h_valid) |-> d2h_data == START_DELIM)
      else $error("response frame without delimiter");
   a_refuse_after: assert property (ok |-> ##[1:2] !h2d_ready)
      else $error("no refusal after checksum");
   a_not_early: assert property (ok |=> !d2h_valid)
      else $error("answer before execution");
   a_answer_due: assert property (ok && due |-> ##[1:3] (d2h_valid && d2h_data == START_DELIM))
      else $error("response did not start");
   a_busy_refuse: assert property (ok && due |-> ##2 !h2d_ready [*4])
      else $error("byte accepted while answering");
   a_zero_silent: assert property (ok && !due |=> !d2h_valid [*6])
      else $error("response for suppressed request");
   a_silent_back: assert property (ok && !due |-> ##3 h2d_ready)
      else $error("ready not back after silent request");
endmodule

// file: tb/test_api_frame_command_handler.sv
`timescale 1ns/10ps
module test_api_frame_command_handler;
   import api_frame_pkg::*;
   // ==========
   // stimulus and observation
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [1:0] mode = 2'd0;
   logic rx_explicit = 1'b0;
   logic [7:0] cause = 8'h00;
   logic rf_valid = 1'b0;
   logic [7:0] rf_byte = 8'h00;
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_type = 8'h00;
   logic [7:0] cmd_id = 8'h00;
   logic [15:0] cmd_code = 16'h0000;
   logic [2:0] cmd_plen = 3'd0;
   logic [31:0] cmd_param = 32'h0000_0000;
   wire cmd_ready, rsp_valid, rf_ack, param_wr;
   wire [7:0] rsp_type, rsp_id;
   wire [15:0] rsp_len, param_code;
   wire [63:0] rsp_data;
   wire [31:0] param_value;
   int errors = 0, tests_run = 0, cyc = 0, rsp_n = 0, pw_n = 0;
   logic [7:0] c_type, c_id, id;
   logic [15:0] c_len, pw_code, code;
   logic [63:0] c_data;
   logic [31:0] pw_val, v;
   logic [31:0] store [8];
   logic [7:0] q2 [$];
   logic [55:0] e7;
   always #20 clk = ~clk;
   api_link_if link (.clk(clk));
   api_link_if link2 (.clk(clk));
   assign link2.d2h_ready = 1'b1;
   initial link2.h2d_valid = 1'b0;
   api_frame_device u_api_frame_device (.clk(clk), .reset(reset), .link(link),
      .api_framing_select(mode), .rx_explicit(rx_explicit), .delivery_cause(cause),
      .rf_valid(rf_valid), .rf_byte(rf_byte), .rf_ack(rf_ack), .param_wr(param_wr),
      .param_code(param_code), .param_value(param_value));
   api_frame_device u_api_frame_device_b (.clk(clk), .reset(reset), .link(link2),
      .api_framing_select(2'd0), .rx_explicit(1'b0), .delivery_cause(cause), .rf_valid(1'b0),
      .rf_byte(8'h00), .rf_ack(), .param_wr(), .param_code(), .param_value());
   api_frame_host u_api_frame_host (.clk(clk), .reset(reset), .link(link),
      .api_framing_select(mode), .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_id(cmd_id),
      .cmd_code(cmd_code), .cmd_plen(cmd_plen), .cmd_param(cmd_param), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_type(rsp_type), .rsp_id(rsp_id), .rsp_len(rsp_len),
      .rsp_data(rsp_data));
   api_frame_monitor u_api_frame_monitor (.clk(clk), .reset(reset), .h2d_data(link.h2d_data),
      .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready), .d2h_data(link.d2h_data),
      .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready));
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rsp_valid === 1'b1) begin
         rsp_n <= rsp_n + 1;
         {c_type, c_id, c_len, c_data} <= {rsp_type, rsp_id, rsp_len, rsp_data};
      end
      if (param_wr === 1'b1) begin
         pw_n <= pw_n + 1;
         {pw_code, pw_val} <= {param_code, param_value};
      end
      if (link2.d2h_valid === 1'b1) q2.push_back(link2.d2h_data);
      if (cyc == 40000) begin
         errors++;
         tally_and_finish();
      end
   end
   // ==========
   // tasks
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic req(input logic [7:0] t, i, input logic [15:0] cd, input logic [2:0] pl,
         input logic [31:0] p, input logic [7:0] et, input logic [15:0] el, input logic [63:0] ed);
      int n;
      int r0;
      logic none;
      none = (i == ID_NONE && et != T_REMOTE_RSP);
      n = 0;
      while (cmd_ready !== 1'b1 && n < 400) begin
         n++;
         @(negedge clk);
      end
      r0 = rsp_n;
      {cmd_type, cmd_id, cmd_code, cmd_plen, cmd_param} = {t, i, cd, pl, p};
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_n == r0 && n < 300) begin
         n++;
         @(negedge clk);
      end
      check("responses", 64'(rsp_n - r0), 64'(!none));
      if (!none) begin
         check("type", c_type, et);
         check("frame id", c_id, i);
         check("length", c_len, el);
         check("body", c_data & ((64'h1 << (8 * (el - 16'd2))) - 64'h1), ed);
      end
   endtask
   task automatic lcl(input logic [7:0] t, i, input logic [15:0] cd, input logic [2:0] pl,
         input logic [31:0] p);
      logic q;
      int p0;
      q = (pl == 3'd0);
      p0 = pw_n;
      req(t, i, cd, pl, p, T_LOCAL_RSP, 16'(q ? LEN_QUERY_RSP : LEN_CMD_RSP),
         q ? {8'h00, cd, ST_OK, store[cd[2:0]]} : {40'h0, cd, ST_OK});
      if (t == T_LOCAL_CMD && !q) begin
         store[cd[2:0]] = p;
         check("writes", 64'(pw_n - p0), 64'd1);
         check("written", {pw_code, pw_val}, {cd, p});
      end
   endtask
   task automatic radio(input logic x, input logic [7:0] rb);
      int n;
      int r0;
      r0 = rsp_n;
      {rx_explicit, rf_byte, rf_valid} = {x, rb, 1'b1};
      n = 0;
      while (rsp_n == r0 && n < 200) begin
         if (rf_ack === 1'b1) rf_valid = 1'b0;
         n++;
         @(negedge clk);
      end
      check("radio ack", rf_valid, 1'b0);
      rf_valid = 1'b0;
      check("radio type", c_type, x ? T_RX_EXPL : T_RX_PLAIN);
      check("radio field", c_id, x ? RX_EXPL_ENDPOINT : rb);
      check("radio length", c_len, x ? 16'd3 : 16'd2);
   endtask
   task automatic put(input logic [7:0] pb);
      int n;
      n = 0;
      {link2.h2d_data, link2.h2d_valid} = {pb, 1'b1};
      while (link2.h2d_ready !== 1'b1 && n < 100) begin
         n++;
         @(negedge clk);
      end
      @(negedge clk);
   endtask
   task automatic raw(input logic [7:0] t, i, input logic bad, input int n_exp);
      q2 = {};
      put(8'h55);
      put(START_DELIM);
      put(LEN_HI_BYTE);
      put(8'h02);
      put(t);
      put(i);
      put(8'(SUM_GOOD - t - i) ^ {7'h0, bad});
      link2.h2d_valid = 1'b0;
      repeat (40) @(negedge clk);
      check("bytes out", 64'(q2.size()), 64'(n_exp));
   endtask
   // ==========
   // sequence
   initial begin
      void'($urandom(32'h7497_cc1a));
      repeat (12) @(negedge clk);
      reset = 1'b0;
      lcl(T_LOCAL_CMD, 8'h17, 16'h5450, 3'd4, 32'h0102_0304);
      lcl(T_LOCAL_CMD, 8'h17, 16'h5450, 3'd0, 32'h0);
      lcl(T_QUEUE_CMD, 8'h05, 16'h5450, 3'd4, 32'h0A0B_0C0D);
      lcl(T_QUEUE_CMD, 8'h06, 16'h5450, 3'd0, 32'h0);
      lcl(T_QUEUE_CMD, 8'h07, APPLY_CODE, 3'd1, 32'h0);
      store[0] = 32'h0A0B_0C0D;
      lcl(T_QUEUE_CMD, 8'h08, 16'h5450, 3'd0, 32'h0);
      lcl(T_LOCAL_CMD, ID_NONE, 16'h5450, 3'd4, 32'h0102_0304);
      req(T_TX_REQ, ID_NONE, 16'h0, 3'd0, 32'h0, T_TX_STATUS, 16'd3, 64'h0);
      req(T_REMOTE_CMD, ID_NONE, 16'h0, 3'd0, 32'h0, T_REMOTE_RSP, 16'd3, 64'h4);
      radio(1'b0, 8'h5A);
      radio(1'b1, 8'h3C);
      cause = 8'h24;
      raw(T_TX_REQ, 8'h21, 1'b1, 0);
      raw(8'h55, 8'h21, 1'b0, 0);
      raw(T_TX_REQ, 8'h21, 1'b0, 7);
      e7 = {START_DELIM, LEN_HI_BYTE, 8'h03, T_TX_STATUS, 8'h21, cause, 8'h2F};
      for (int k = 0; k < 7; k++) check("wire byte", q2[k], e7[55 - 8 * k -: 8]);
      mode = MODE_ESCAPED;
      for (int i = 0; i < 40; i++) begin
         code = {8'($urandom_range(8'h5A, 8'h41)), 8'($urandom_range(8'h5A, 8'h41))};
         if (code == APPLY_CODE) code = 16'h5A5A;
         {id, v, cause} = {8'($urandom), $urandom, 8'($urandom)};
         lcl(T_LOCAL_CMD, id, code, 3'd4, v);
         lcl($urandom_range(1) ? T_QUEUE_CMD : T_LOCAL_CMD, 8'($urandom), code, 3'd0, 0);
         req($urandom_range(1) ? T_TX_EXPL : T_TX_REQ, id, code, 3'd0, 32'h0, T_TX_STATUS,
            16'd3, {56'h0, cause});
         req(T_REMOTE_CMD, 8'($urandom_range(3)), code, 3'd0, 32'h0, T_REMOTE_RSP, 16'd3,
            {56'h0, ST_REMOTE_NO_ACK});
      end
      tally_and_finish();
   end
endmodule
